// file: rtl/timer_pkg.sv
// Package: register map, reset values and field positions of the five channel timer core
package timer_pkg;
  // ==========================================
  // Register addresses (word index on the 16-bit bus)
  localparam logic [5:0] ADDR_CNT0 = 6'h00;
  localparam logic [5:0] ADDR_CNT4 = 6'h04;
  localparam logic [5:0] ADDR_COMPARE_A_CH0 = 6'h08;
  localparam logic [5:0] ADDR_COMPARE_A_CH4 = 6'h0c;
  localparam logic [5:0] ADDR_COMPARE_B_CH0 = 6'h10;
  localparam logic [5:0] ADDR_COMPARE_B_CH4 = 6'h14;
  localparam logic [5:0] ADDR_BUFFER_A_CH3 = 6'h18;
  localparam logic [5:0] ADDR_BUFFER_B_CH3 = 6'h19;
  localparam logic [5:0] ADDR_BUFFER_A_CH4 = 6'h1a;
  localparam logic [5:0] ADDR_BUFFER_B_CH4 = 6'h1b;
  localparam logic [5:0] ADDR_COMB = 6'h1c;
  localparam logic [5:0] ADDR_OLVL = 6'h1d;
  localparam logic [5:0] ADDR_START = 6'h1e;
  localparam logic [5:0] ADDR_CHCFG0 = 6'h20;
  localparam logic [5:0] ADDR_CHCFG4 = 6'h24;
  localparam logic [5:0] ADDR_STAT0 = 6'h28;
  localparam logic [5:0] ADDR_STAT4 = 6'h2c;
  // ==========================================
  // Reset values, counter maximum and fixed read bits
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] GR_RESET = 16'hffff;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [5:0] COMB_RESET = 6'h00;
  localparam logic [1:0] OLVL_RESET = 2'h3;
  localparam logic [7:0] COMB_FIXED = 8'h40;
  localparam logic [7:0] OLVL_FIXED = 8'h7c;
  // ==========================================
  // Field positions, pairing codes and channel count
  localparam int COMB_SEL_HI = 5;
  localparam int COMB_SEL_LO = 4;
  localparam logic [1:0] COMB_COMPL = 2'h2;
  localparam logic [1:0] COMB_RSYNC = 2'h3;
  localparam int CFG_IOA_CAP = 0;
  localparam int CFG_IOA_OE = 1;
  localparam int CFG_IOB_CAP = 2;
  localparam int CFG_IOB_OE = 3;
  localparam int CFG_CLR_A = 4;
  localparam int CFG_CLR_B = 5;
  localparam int CFG_PWM = 6;
  localparam int CFG_DOWN_EN = 7;
  localparam int STAT_MATCH_CAPTURE_FLAG_A = 0;
  localparam int STAT_MATCH_CAPTURE_FLAG_B = 1;
  localparam int STAT_OVF = 2;
  localparam int NCH = 5;
endpackage

// file: rtl/byte_lane_write.sv
// Byte lane merge for 16-bit registers
`timescale 1ns/1ps
module byte_lane_write (
  input wire logic [15:0] old_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] be_i,
  output logic [15:0] merged_o
);
  assign merged_o = {be_i[1] ? wdata_i[15:8] : old_i[15:8],
                     be_i[0] ? wdata_i[7:0] : old_i[7:0]};
endmodule

// file: rtl/edge_capture_sync.sv
// Two-stage synchroniser with edge detect for capture pins
`timescale 1ns/1ps
module edge_capture_sync (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic rise_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Only the second and third stages feed the edge detector
  assign rise_o = s2_q & ~s3_q;
endmodule

// file: rtl/five_channel_timer_compare_core.sv
// Top of the five channel 16-bit timer compare/capture core
// What this block does
// - Combination/buffer control is 8 bits, resets to 0x40, bit 6 reads one.
// - Bits 5:4 select normal, complementary PWM or reset-synchronised PWM pairing.
// - Combination PWM selection overrides channel 3 and 4 PWM mode bits.
// - Four buffer enables pair compare registers with buffer registers for channels 3, 4.
// - Level bit 1 inverts ch3 A and ch4 A/B outputs in combination modes only.
// - Level bit 0 inverts ch3 B and ch4 complementary outputs in combination modes.
// - Output level control is 8 bits, resets to 0x7F, bits 6:2 read one.
// - Five 16-bit counters, one per channel, each advancing on its count tick.
// - Counters 0,1 only up; 2 up/down in phase mode; 3,4 in complementary PWM.
// - Counter clears on A or B match or capture when its clear selection asks.
// - Overflow flag sets on wrap up from all ones and down from zero.
// - Counters, compare and buffer registers are word or byte accessible.
// - Counters reset to zero.
// - Each channel has compare registers A and B, compare or capture by config.
// - Output compare matches set the flag and drive the pin level when enabled.
// - Capture edge latches counter and sets flag in the same cycle.
// - Compare/capture selection is ignored in PWM and combination modes.
// - Compare registers reset to 0xFFFF as compare with pin output disabled.
// - Buffered compare match copies buffer into compare register; buffers reset 0xFFFF.
// - Buffered capture moves old compare value to buffer before latching new.
`timescale 1ns/1ps
module five_channel_timer_compare_core (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic standby_i,
  input wire logic [5:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] be_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [4:0] count_tick_i,
  input wire logic [4:0] phase_down_i,
  input wire logic [4:0] cap_a_i,
  input wire logic [4:0] cap_b_i,
  output logic [15:0] rdata_o,
  output logic [4:0] pin_a_o,
  output logic [4:0] pin_b_o,
  output logic [4:0] pin_a_oe_o,
  output logic [4:0] pin_b_oe_o,
  output logic ch4_comp_out_a_o,
  output logic ch4_comp_out_b_o
);
  localparam int N = timer_pkg::NCH;
  // ==========================================
  // State
  logic init;
  logic [15:0] cnt_q [N];
  logic [15:0] gra_q [N];
  logic [15:0] grb_q [N];
  logic [15:0] bra_q [2];
  logic [15:0] brb_q [2];
  logic [7:0] cfg_q [N];
  logic [2:0] stat_q [N];
  logic [2:0] seen_q [N];
  logic [4:0] start_q;
  logic [5:0] comb_q;
  logic [1:0] olvl_q;
  logic [4:0] pa_q;
  logic [4:0] pb_q;
  logic [4:0] pa_oe_q;
  logic [4:0] pb_oe_q;
  logic cxa_q;
  logic cxb_q;
  logic [15:0] rdata_q;
  logic [4:0] cap_a_rise;
  logic [4:0] cap_b_rise;
  logic [4:0] tick_s1_q;
  logic [4:0] tick_s2_q;
  logic [4:0] dir_s1_q;
  logic [4:0] dir_s2_q;
  assign init = rst_i | standby_i;
  // ==========================================
  // Pin inputs
  always_ff @(posedge clock_i) begin
    tick_s1_q <= count_tick_i;
    tick_s2_q <= tick_s1_q;
    dir_s1_q <= phase_down_i;
    dir_s2_q <= dir_s1_q;
  end
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_sync
      edge_capture_sync u_sa (.clock_i(clock_i), .rst_i(init), .pin_i(cap_a_i[g]),
                              .rise_o(cap_a_rise[g]));
      edge_capture_sync u_sb (.clock_i(clock_i), .rst_i(init), .pin_i(cap_b_i[g]),
                              .rise_o(cap_b_rise[g]));
    end
  endgenerate
  // ==========================================
  // Decode
  wire [1:0] comb_sel = comb_q[timer_pkg::COMB_SEL_HI:timer_pkg::COMB_SEL_LO];
  wire compl_mode = (comb_sel == timer_pkg::COMB_COMPL);
  wire rsync_mode = (comb_sel == timer_pkg::COMB_RSYNC);
  wire comb_mode = compl_mode | rsync_mode;
  wire [3:0] buf_en = comb_q[3:0];
  wire [7:0] comb_rd = timer_pkg::COMB_FIXED | {2'h0, comb_q};
  wire [7:0] olvl_rd = timer_pkg::OLVL_FIXED | {6'h00, olvl_q};
  wire [15:0] cur_rd;
  function automatic logic in_range(input logic [5:0] a, input logic [5:0] lo);
    in_range = (a >= lo) && (a < lo + 6'(N));
  endfunction
  function automatic logic [2:0] idx(input logic [5:0] a, input logic [5:0] lo);
    idx = 3'(a - lo);
  endfunction
  wire sel_cnt = in_range(addr_i, timer_pkg::ADDR_CNT0);
  wire sel_gra = in_range(addr_i, timer_pkg::ADDR_COMPARE_A_CH0);
  wire sel_grb = in_range(addr_i, timer_pkg::ADDR_COMPARE_B_CH0);
  wire sel_cfg = in_range(addr_i, timer_pkg::ADDR_CHCFG0);
  wire sel_stat = in_range(addr_i, timer_pkg::ADDR_STAT0);
  wire [2:0] ci = idx(addr_i, sel_cnt ? timer_pkg::ADDR_CNT0 : sel_gra ? timer_pkg::ADDR_COMPARE_A_CH0 :
                   sel_grb ? timer_pkg::ADDR_COMPARE_B_CH0 : sel_cfg ? timer_pkg::ADDR_CHCFG0 :
                   timer_pkg::ADDR_STAT0);
  wire [1:0] bi = addr_i[1:0];
  wire sel_bra = (addr_i == timer_pkg::ADDR_BUFFER_A_CH3) || (addr_i == timer_pkg::ADDR_BUFFER_A_CH4);
  wire sel_brb = (addr_i == timer_pkg::ADDR_BUFFER_B_CH3) || (addr_i == timer_pkg::ADDR_BUFFER_B_CH4);
  wire [0:0] bch = (addr_i == timer_pkg::ADDR_BUFFER_A_CH4) || (addr_i == timer_pkg::ADDR_BUFFER_B_CH4);
  assign cur_rd = sel_cnt ? cnt_q[ci] : sel_gra ? gra_q[ci] : sel_grb ? grb_q[ci] :
                  sel_bra ? bra_q[bch] : sel_brb ? brb_q[bch] :
                  sel_cfg ? {8'h00, cfg_q[ci]} : sel_stat ? {13'h0000, stat_q[ci]} :
                  (addr_i == timer_pkg::ADDR_COMB) ? {8'h00, comb_rd} :
                  (addr_i == timer_pkg::ADDR_OLVL) ? {8'h00, olvl_rd} :
                  (addr_i == timer_pkg::ADDR_START) ? {11'h000, start_q} : 16'h0000;
  logic [15:0] merged;
  byte_lane_write u_merge (.old_i(cur_rd), .wdata_i(wdata_i), .be_i(be_i),
                           .merged_o(merged));
  // ==========================================
  // Per channel events
  logic [4:0] pwm_eff;
  logic [4:0] cap_a_mode;
  logic [4:0] cap_b_mode;
  logic [4:0] ev_a;
  logic [4:0] ev_b;
  logic [4:0] match_a;
  logic [4:0] match_b;
  logic [4:0] counting_down;
  logic [4:0] tick;
  always_comb begin
    for (int c = 0; c < N; c++) begin
      tick[c] = tick_s2_q[c] & start_q[c];
      // Combination modes take precedence over per-channel PWM on channels 3 and 4
      pwm_eff[c] = (c >= 3) ? (comb_mode | cfg_q[c][timer_pkg::CFG_PWM])
                            : cfg_q[c][timer_pkg::CFG_PWM];
      cap_a_mode[c] = cfg_q[c][timer_pkg::CFG_IOA_CAP] & ~pwm_eff[c];
      cap_b_mode[c] = cfg_q[c][timer_pkg::CFG_IOB_CAP] & ~pwm_eff[c];
      match_a[c] = ~cap_a_mode[c] & (cnt_q[c] == gra_q[c]);
      match_b[c] = ~cap_b_mode[c] & (cnt_q[c] == grb_q[c]);
      ev_a[c] = cap_a_mode[c] ? cap_a_rise[c] : match_a[c];
      ev_b[c] = cap_b_mode[c] ? cap_b_rise[c] : match_b[c];
      // Down counting only where the mode allows it
      counting_down[c] = dir_s2_q[c] & cfg_q[c][timer_pkg::CFG_DOWN_EN] &
                         (c == 2 || ((c >= 3) && compl_mode));
    end
  end
  wire bus_wr = wr_i & (be_i != 2'b00);
  // ==========================================
  // Channel registers
  always_ff @(posedge clock_i) begin
    if (init) begin
      for (int c = 0; c < N; c++) begin
        cnt_q[c] <= timer_pkg::CNT_RESET;
        gra_q[c] <= timer_pkg::GR_RESET;
        grb_q[c] <= timer_pkg::GR_RESET;
        cfg_q[c] <= 8'h00;
        stat_q[c] <= 3'h0;
        seen_q[c] <= 3'h0;
      end
      for (int k = 0; k < 2; k++) begin
        bra_q[k] <= timer_pkg::GR_RESET;
        brb_q[k] <= timer_pkg::GR_RESET;
      end
    end else begin
      for (int c = 0; c < N; c++) begin
        // Counter: clear beats count, bus write beats both
        if (bus_wr && sel_cnt && ci == 3'(c)) begin
          cnt_q[c] <= merged;
        end else if ((cfg_q[c][timer_pkg::CFG_CLR_A] && ev_a[c]) ||
                     (cfg_q[c][timer_pkg::CFG_CLR_B] && ev_b[c])) begin
          cnt_q[c] <= timer_pkg::CNT_RESET;
        end else if (tick[c]) begin
          cnt_q[c] <= counting_down[c] ? cnt_q[c] - 16'h0001 : cnt_q[c] + 16'h0001;
        end
        // Compare register A
        if (bus_wr && sel_gra && ci == 3'(c)) begin
          gra_q[c] <= merged;
        end else if (cap_a_mode[c] && cap_a_rise[c]) begin
          gra_q[c] <= cnt_q[c];
        // Index folded from the channel number so channels 0 to 2 never select out of range
        end else if (c >= 3 && buf_en[{1'(c + 1), 1'b0}] && match_a[c]) begin
          gra_q[c] <= bra_q[1'(c + 1)];
        end
        if (bus_wr && sel_grb && ci == 3'(c)) begin
          grb_q[c] <= merged;
        end else if (cap_b_mode[c] && cap_b_rise[c]) begin
          grb_q[c] <= cnt_q[c];
        end else if (c >= 3 && buf_en[{1'(c + 1), 1'b1}] && match_b[c]) begin
          grb_q[c] <= brb_q[1'(c + 1)];
        end
        if (bus_wr && sel_cfg && ci == 3'(c)) begin
          cfg_q[c] <= merged[7:0];
        end
        // Flags: a hardware set wins over a software clear in the same cycle
        begin
          logic [2:0] hw;
          logic [2:0] clr;
          hw = {tick[c] && (counting_down[c] ? cnt_q[c] == timer_pkg::CNT_RESET
                                             : cnt_q[c] == timer_pkg::CNT_MAX),
                ev_b[c], ev_a[c]};
          clr = (bus_wr && be_i[0] && sel_stat && ci == 3'(c)) ?
                (seen_q[c] & ~wdata_i[2:0]) : 3'h0;
          stat_q[c] <= (stat_q[c] & ~clr) | hw;
          if (rd_i && sel_stat && ci == 3'(c)) begin
            seen_q[c] <= stat_q[c];
          end else begin
            seen_q[c] <= seen_q[c] & ~clr;
          end
        end
      end
      for (int k = 0; k < 2; k++) begin
        if (bus_wr && sel_bra && bch == 1'(k)) begin
          bra_q[k] <= merged;
        end else if (buf_en[k * 2] && cap_a_mode[k + 3] && cap_a_rise[k + 3]) begin
          bra_q[k] <= gra_q[k + 3];
        end
        if (bus_wr && sel_brb && bch == 1'(k)) begin
          brb_q[k] <= merged;
        end else if (buf_en[k * 2 + 1] && cap_b_mode[k + 3] && cap_b_rise[k + 3]) begin
          brb_q[k] <= grb_q[k + 3];
        end
      end
    end
  end
  // ==========================================
  // Global control and read data
  always_ff @(posedge clock_i) begin
    if (init) begin
      comb_q <= timer_pkg::COMB_RESET;
      olvl_q <= timer_pkg::OLVL_RESET;
      start_q <= 5'h00;
      rdata_q <= 16'h0000;
    end else begin
      if (bus_wr && be_i[0] && addr_i == timer_pkg::ADDR_COMB) begin
        comb_q <= wdata_i[5:0];
      end
      if (bus_wr && be_i[0] && addr_i == timer_pkg::ADDR_OLVL) begin
        olvl_q <= wdata_i[1:0];
      end
      if (bus_wr && be_i[0] && addr_i == timer_pkg::ADDR_START) begin
        start_q <= wdata_i[4:0];
      end
      rdata_q <= rd_i ? cur_rd : 16'h0000;
    end
  end
  // ==========================================
  // Pin outputs
  logic [4:0] pa_d;
  logic [4:0] pb_d;
  always_comb begin
    pa_d = pa_q;
    pb_d = pb_q;
    for (int c = 0; c < N; c++) begin
      if (pwm_eff[c]) begin
        if (match_a[c]) pa_d[c] = 1'b1;
        if (match_b[c]) pa_d[c] = 1'b0;
      end else begin
        if (match_a[c] && cfg_q[c][timer_pkg::CFG_IOA_OE]) pa_d[c] = ~pa_q[c];
        if (match_b[c] && cfg_q[c][timer_pkg::CFG_IOB_OE]) pb_d[c] = ~pb_q[c];
      end
    end
  end
  // Waveform detail of the combination modes is simplified: the inversion only
  wire inv1 = comb_mode & ~olvl_q[1];
  wire inv0 = comb_mode & ~olvl_q[0];
  // Inversion is folded in ahead of the pin flops, so a level change shows one cycle later
  logic [4:0] pin_a_q;
  logic [4:0] pin_b_q;
  always_ff @(posedge clock_i) begin
    if (init) begin
      pa_q <= 5'h00;
      pb_q <= 5'h00;
      pin_a_q <= 5'h00;
      pin_b_q <= 5'h00;
      pa_oe_q <= 5'h00;
      pb_oe_q <= 5'h00;
      cxa_q <= 1'b0;
      cxb_q <= 1'b0;
    end else begin
      pa_q <= pa_d;
      pb_q <= pb_d;
      pin_a_q <= pa_d ^ {inv1, inv1, 3'b000};
      pin_b_q <= pb_d ^ {inv1, inv0, 3'b000};
      for (int c = 0; c < N; c++) begin
        pa_oe_q[c] <= pwm_eff[c] | (~cap_a_mode[c] & cfg_q[c][timer_pkg::CFG_IOA_OE]);
        pb_oe_q[c] <= (c >= 3 && comb_mode) |
                      (~pwm_eff[c] & ~cap_b_mode[c] & cfg_q[c][timer_pkg::CFG_IOB_OE]);
      end
      cxa_q <= (comb_mode & ~pa_d[4]) ^ inv0;
      cxb_q <= (comb_mode & ~pb_d[4]) ^ inv0;
    end
  end
  assign pin_a_o = pin_a_q;
  assign pin_b_o = pin_b_q;
  assign ch4_comp_out_a_o = cxa_q;
  assign ch4_comp_out_b_o = cxb_q;
  assign pin_a_oe_o = pa_oe_q;
  assign pin_b_oe_o = pb_oe_q;
  assign rdata_o = rdata_q;
endmodule

// file: tb/timer_core_properties.sv
// Checker: port-level properties of the five channel timer core
`timescale 1ns/1ps
module timer_core_properties (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic standby_i,
  input wire logic [5:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] be_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [4:0] pin_a_o,
  input wire logic [4:0] pin_b_o,
  input wire logic [4:0] pin_a_oe_o,
  input wire logic [4:0] pin_b_oe_o,
  input wire logic ch4_comp_out_a_o,
  input wire logic ch4_comp_out_b_o
);
  // ==========================================
  // Shadow of the writable control fields
  logic [5:0] comb_q;
  logic [1:0] lvl_q;
  logic wr_lo;
  logic [5:0] outs;
  assign wr_lo = wr_i && be_i[0];
  assign outs = {pin_a_o[4:3], pin_b_o[4], pin_b_o[3], ch4_comp_out_a_o, ch4_comp_out_b_o};
  always_ff @(posedge clock_i) begin
    if (rst_i || standby_i) begin
      comb_q <= 6'h00;
      lvl_q <= 2'h3;
    end else begin
      if (wr_lo && addr_i == timer_pkg::ADDR_COMB) comb_q <= wdata_i[5:0];
      if (wr_lo && addr_i == timer_pkg::ADDR_OLVL) lvl_q <= wdata_i[1:0];
    end
  end
  // ==========================================
  // Properties
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i || standby_i);
  read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero without a read");
  comb_fixed_a: assert property (
    $past(rd_i && addr_i == timer_pkg::ADDR_COMB) |-> rdata_o[15:6] == 10'h001)
    else $error("combination register fixed bits wrong");
  comb_field_a: assert property (
    $past(rd_i && addr_i == timer_pkg::ADDR_COMB) |-> rdata_o[5:0] == $past(comb_q))
    else $error("combination register field lost");
  level_fixed_a: assert property (
    $past(rd_i && addr_i == timer_pkg::ADDR_OLVL) |-> rdata_o[15:2] == 14'h001f)
    else $error("level register fixed bits wrong");
  level_field_a: assert property (
    $past(rd_i && addr_i == timer_pkg::ADDR_OLVL) |-> rdata_o[1:0] == $past(lvl_q))
    else $error("level register field lost");
  unmapped_zero_a: assert property (
    $past(rd_i && addr_i > 6'h2c) |-> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  reset_oe_a: assert property (
    $fell(rst_i || standby_i) |-> pin_a_oe_o == 5'h00 && pin_b_oe_o == 5'h00)
    else $error("pin output enabled after reset");
  // Level register update lands one edge after the write, the pin flops one edge later
  invert_a_a: assert property (
    wr_lo && addr_i == timer_pkg::ADDR_OLVL && comb_q[5] && wdata_i[1] != lvl_q[1]
    |=> ##1 outs[5:3] == ~$past(outs[5:3], 2))
    else $error("group one level not inverted");
  invert_b_a: assert property (
    wr_lo && addr_i == timer_pkg::ADDR_OLVL && comb_q[5] && wdata_i[0] != lvl_q[0]
    |=> ##1 outs[2:0] == ~$past(outs[2:0], 2))
    else $error("group two level not inverted");
  cover property (rd_i && addr_i == timer_pkg::ADDR_COMB);
  cover property (wr_lo && addr_i == timer_pkg::ADDR_OLVL && comb_q[5]);
  cover property ($fell(standby_i));
endmodule

bind five_channel_timer_compare_core timer_core_properties u_timer_core_properties (
  .clock_i(clock_i), .rst_i(rst_i), .standby_i(standby_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .be_i(be_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .pin_a_o(pin_a_o), .pin_b_o(pin_b_o), .pin_a_oe_o(pin_a_oe_o), .pin_b_oe_o(pin_b_oe_o),
  .ch4_comp_out_a_o(ch4_comp_out_a_o), .ch4_comp_out_b_o(ch4_comp_out_b_o));

// file: tb/pin_driver_model.sv
// Far-side model: count tick and capture pins seen by the timer core
`timescale 1ns/1ps
module pin_driver_model (
  input wire logic clock_i,
  output logic [4:0] count_tick_o,
  output logic [4:0] cap_a_o
);
  initial begin
    count_tick_o = 5'h00;
    cap_a_o = 5'h00;
  end
  // One pulse per call; the quiet gap covers the core's input synchroniser
  task automatic drive(input logic [4:0] t, input logic [4:0] a);
    @(posedge clock_i);
    count_tick_o <= t;
    cap_a_o <= a;
    @(posedge clock_i);
    count_tick_o <= 5'h00;
    cap_a_o <= 5'h00;
    repeat (8) @(posedge clock_i);
  endtask
endmodule

// file: tb/tb_top.sv
// Testbench: register-level scenarios for the five channel timer core
`timescale 1ns/1ps
module tb_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic standby_i = 1'b0;
  logic [5:0] addr_i = 6'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic [1:0] be_i = 2'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [4:0] tick, cap, pin_a, pin_b, oe_a, oe_b;
  logic [15:0] rdata;
  logic comp_a, comp_b;
  logic [5:0] lv, pv;
  logic [4:0] dir = 5'h00;
  int n_fail = 0;
  int tests_run = 0;
  int i;
  assign lv = {pin_a[4:3], pin_b[4], pin_b[3], comp_a, comp_b};
  always #50 clock_i = ~clock_i;
  pin_driver_model u_pin_driver_model (.clock_i(clock_i), .count_tick_o(tick), .cap_a_o(cap));
  five_channel_timer_compare_core u_five_channel_timer_compare_core (
    .clock_i(clock_i), .rst_i(rst_i), .standby_i(standby_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .be_i(be_i), .wr_i(wr_i), .rd_i(rd_i), .count_tick_i(tick),
    .phase_down_i(dir), .cap_a_i(cap), .cap_b_i(cap), .rdata_o(rdata),
    .pin_a_o(pin_a), .pin_b_o(pin_b), .pin_a_oe_o(oe_a), .pin_b_oe_o(oe_b),
    .ch4_comp_out_a_o(comp_a), .ch4_comp_out_b_o(comp_b));
  // ==========================================
  // Bus tasks and comparison
  task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    be_i <= be;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // Reserved status bits are left unchecked
  task automatic st(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(d & 16'h0007, e);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    rc(timer_pkg::ADDR_COMB, 16'h0040);
    rc(timer_pkg::ADDR_OLVL, 16'h007f);
    for (i = 0; i < 5; i++) begin
      rc(6'(timer_pkg::ADDR_CNT0 + i), 16'h0000);
      rc(6'(timer_pkg::ADDR_COMPARE_A_CH0 + i), 16'hffff);
      rc(6'(timer_pkg::ADDR_COMPARE_B_CH0 + i), 16'hffff);
    end
    for (i = 0; i < 4; i++) begin
      rc(6'(timer_pkg::ADDR_BUFFER_A_CH3 + i), 16'hffff);
    end
    // Every pairing code, with counters 3 and 4 stopped throughout
    for (i = 0; i < 4; i++) begin
      wr(timer_pkg::ADDR_COMB, 16'(i * 17), 2'b01);
      rc(timer_pkg::ADDR_COMB, 16'h0040 | 16'(i * 17));
      pv = lv;
      wr(timer_pkg::ADDR_OLVL, 16'h0000, 2'b01);
      rc(timer_pkg::ADDR_OLVL, 16'h007c);
      chk(16'(lv ^ pv), (i > 1) ? 16'h003f : 16'h0000);
      chk(16'({oe_a, oe_b}), (i > 1) ? 16'h0318 : 16'h0000);
      wr(timer_pkg::ADDR_OLVL, 16'h00ff, 2'b01);
    end
    wr(timer_pkg::ADDR_COMB, 16'h0000, 2'b01);
    wr(timer_pkg::ADDR_CNT0 + 6'h01, 16'h1234, 2'b11);
    wr(timer_pkg::ADDR_CNT0 + 6'h01, 16'habcd, 2'b10);
    rc(timer_pkg::ADDR_CNT0 + 6'h01, 16'hab34);
    wr(timer_pkg::ADDR_COMPARE_B_CH0 + 6'h02, 16'h5566, 2'b01);
    rc(timer_pkg::ADDR_COMPARE_B_CH0 + 6'h02, 16'hff66);
    wr(timer_pkg::ADDR_BUFFER_B_CH4, 16'h7788, 2'b10);
    rc(timer_pkg::ADDR_BUFFER_B_CH4, 16'h77ff);
    rc(6'h3f, 16'h0000);
    // Wrap through all ones, then match on A with clear and toggle
    wr(timer_pkg::ADDR_CNT0, 16'hfffe, 2'b11);
    wr(timer_pkg::ADDR_COMPARE_A_CH0, 16'h0002, 2'b11);
    wr(timer_pkg::ADDR_CHCFG0, 16'h0012, 2'b01);
    wr(timer_pkg::ADDR_START, 16'h0001, 2'b01);
    repeat (2) u_pin_driver_model.drive(5'h01, 5'h00);
    rc(timer_pkg::ADDR_CNT0, 16'h0000);
    st(timer_pkg::ADDR_STAT0, 16'h0006);
    repeat (2) u_pin_driver_model.drive(5'h01, 5'h00);
    rc(timer_pkg::ADDR_CNT0, 16'h0000);
    chk(16'({pin_a[0], oe_a[0]}), 16'h0003);
    wr(timer_pkg::ADDR_STAT0, 16'h0000, 2'b01);
    st(timer_pkg::ADDR_STAT0, 16'h0001);
    wr(timer_pkg::ADDR_STAT0, 16'h0000, 2'b01);
    st(timer_pkg::ADDR_STAT0, 16'h0000);
    wr(timer_pkg::ADDR_CHCFG0 + 6'h01, 16'h0005, 2'b01);
    wr(timer_pkg::ADDR_START, 16'h0003, 2'b01);
    repeat (3) u_pin_driver_model.drive(5'h02, 5'h00);
    u_pin_driver_model.drive(5'h00, 5'h02);
    rc(timer_pkg::ADDR_COMPARE_A_CH0 + 6'h01, 16'hab37);
    rc(timer_pkg::ADDR_COMPARE_B_CH0 + 6'h01, 16'hab37);
    st(timer_pkg::ADDR_STAT0 + 6'h01, 16'h0003);
    // Buffered compare on channel 3 and buffered capture on channel 4
    wr(timer_pkg::ADDR_COMB, 16'h0005, 2'b01);
    wr(timer_pkg::ADDR_BUFFER_A_CH3, 16'h0010, 2'b11);
    wr(timer_pkg::ADDR_COMPARE_A_CH0 + 6'h03, 16'h0001, 2'b11);
    wr(timer_pkg::ADDR_CHCFG4, 16'h0001, 2'b01);
    wr(timer_pkg::ADDR_COMPARE_A_CH4, 16'h2222, 2'b11);
    wr(timer_pkg::ADDR_CNT4, 16'h0100, 2'b11);
    wr(timer_pkg::ADDR_START, 16'h0018, 2'b01);
    u_pin_driver_model.drive(5'h18, 5'h00);
    u_pin_driver_model.drive(5'h00, 5'h10);
    rc(timer_pkg::ADDR_COMPARE_A_CH0 + 6'h03, 16'h0010);
    rc(timer_pkg::ADDR_BUFFER_A_CH4, 16'h2222);
    rc(timer_pkg::ADDR_COMPARE_A_CH4, 16'h0101);
    // Counter 2 counts down from zero: wraps to all ones and flags the underflow
    @(posedge clock_i);
    dir <= 5'h04;
    wr(timer_pkg::ADDR_CHCFG0 + 6'h02, 16'h0080, 2'b01);
    wr(timer_pkg::ADDR_START, 16'h0004, 2'b01);
    u_pin_driver_model.drive(5'h04, 5'h00);
    rc(timer_pkg::ADDR_CNT0 + 6'h02, 16'hffff);
    st(timer_pkg::ADDR_STAT0 + 6'h02, 16'h0005);
    @(posedge clock_i);
    standby_i <= 1'b1;
    @(posedge clock_i);
    standby_i <= 1'b0;
    rc(timer_pkg::ADDR_CNT4, 16'h0000);
    rc(timer_pkg::ADDR_BUFFER_A_CH4, 16'hffff);
    rc(timer_pkg::ADDR_COMB, 16'h0040);
    report_and_stop();
  end
  // Whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    report_and_stop();
  end
endmodule
